// [shared/core_cfg.svh]
// Purpose: Constants for the core memory bit datapath.
// Assumes: One 100 MHz clock; times are given in ns.
// Notes: Cycle counts are derived from the times below.
// Behaviour
// - Read clears addressed ones; restore rewrites them
// - Inhibit zero bits during restore or write
// - Inhibit only when data and timing high
// - Timing tap fires one fixed rise pulse
// - Cycle end ties lines low until next
// - Thirty-six planes of 128 by 128 cores
// - One X and one Y line select
// - Only the addressed half line is used
// - Address bit 13 selects the half
// - Sensed pulse sets register bit, output low
// - No pulse keeps high; output reads zero
// - High register output enables half inhibit
// - Split cycle samples input at write start
// - Input zero forces register output high
// - Clear write stores input, drives inhibit
// - Decode turns on exactly one switch
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// Word and array geometry
`define CORE_BITS 36
`define CORE_ADDR_BITS 14
`define CORE_WORDS 16384
`define LINE_SEL_BITS 7
`define LINE_COUNT 128
`define HALF_SEL_BIT 13
`define X_SEL_LSB 0
`define Y_SEL_LSB 7

// Clock rate and sequencer times
`define CLK_MHZ 100
`define READ_NS 100
`define WRITE_NS 200
`define RISE_NS 40
`define READ_CYC ((`READ_NS * `CLK_MHZ + 999) / 1000)
`define WRITE_CYC ((`WRITE_NS * `CLK_MHZ + 999) / 1000)
`define RISE_CYC ((`RISE_NS * `CLK_MHZ + 999) / 1000)
`define CNT_BITS 8

`endif

// [shared/core_pkg.sv]
// Purpose: Types shared by the core memory datapath.
// Assumes: core_cfg.svh holds the numbers.
// Notes: Sequencer states carry no fixed codes.
`include "core_cfg.svh"

package core_pkg;

  // One memory word, one bit per plane
  typedef logic [`CORE_BITS-1:0] word_t;

  // Word address
  typedef logic [`CORE_ADDR_BITS-1:0] addr_t;

  // Sequencer count
  typedef logic [`CNT_BITS-1:0] cnt_t;

  // Memory cycle sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CLEAR,
    ST_READ,
    ST_SENSE,
    ST_OUTPUT,
    ST_WAIT_WR,
    ST_LOAD,
    ST_INHIBIT,
    ST_END
  } state_t;

endpackage : core_pkg

// [verilog/core_plane_mem.sv]
// Purpose: Storage of all planes, one word per address.
// Assumes: Single port; read data is registered.
// Notes: A read in a write cycle gets the old word; read data holds until next read.
`timescale 1ns/1ns
`include "core_cfg.svh"

module core_plane_mem import core_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire addr_t addr,
  input wire word_t wr_data,
  output word_t rd_data
);

  // Core array, 36 planes of 16384 cores
  word_t cores [0:`CORE_WORDS-1];
  word_t rd_data_q; // Registered read data

  // Write port, no reset on the array itself
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      cores[addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= cores[addr];
    end
  end

  assign rd_data = rd_data_q;

endmodule : core_plane_mem

// [verilog/drive_decode.sv]
// Purpose: One-hot decode of a drive line select.
// Assumes: Output is combinational; caller registers it.
// Notes: All lines off when not enabled.
`timescale 1ns/1ns
`include "core_cfg.svh"

module drive_decode (
  input wire logic en,
  input wire logic [`LINE_SEL_BITS-1:0] sel,
  output logic [`LINE_COUNT-1:0] lines
);

  // One switch per line, on only when selected
  genvar gi;
  generate
    for (gi = 0; gi < `LINE_COUNT; gi = gi + 1) begin : g_line
      assign lines[gi] = en && (sel == `LINE_SEL_BITS'(gi));
    end
  endgenerate

endmodule : drive_decode

// [verilog/core_memory_bit_datapath.sv]
// Purpose: Read, restore and write datapath of a core memory.
// Assumes: Control pins are asynchronous and are synchronised.
// Notes: Data register is kept in its inverted (output) sense.
`timescale 1ns/1ns
`include "core_cfg.svh"

module core_memory_bit_datapath import core_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cycle_start_n,
  input wire logic [`CORE_ADDR_BITS-1:0] address,
  input wire logic [`CORE_BITS-1:0] data_in,
  input wire logic word_write_n,
  input wire logic split_cycle_n,
  input wire logic write_start_n,
  output logic [`CORE_BITS-1:0] data_out,
  output logic data_out_strobe,
  output logic [`LINE_COUNT-1:0] x_drive,
  output logic [`LINE_COUNT-1:0] y_drive,
  output logic drive_write,
  output logic [`CORE_BITS-1:0] inhibit_lower,
  output logic [`CORE_BITS-1:0] inhibit_upper,
  output logic inhibit_rise,
  output logic sink_discharge,
  output logic cycle_busy
);

  // Synchroniser stages for pins
  logic start_meta_q; // First stage, cycle start
  logic start_sync_q; // Second stage, cycle start
  logic start_last_q; // Previous synced value for edge
  logic wrs_meta_q; // First stage, write start
  logic wrs_sync_q; // Second stage, write start
  logic ww_meta_q; // First stage, word write
  logic ww_sync_q; // Second stage, word write
  logic sc_meta_q; // First stage, split cycle
  logic sc_sync_q; // Second stage, split cycle
  addr_t addr_meta_q; // First stage, address
  addr_t addr_sync_q; // Second stage, address
  word_t din_meta_q; // First stage, data in
  word_t din_sync_q; // Second stage, data in

  // Sequencer state
  state_t state_q; // Current state
  state_t state_d; // Next state
  cnt_t cnt_q; // Phase down counter
  cnt_t cnt_d; // Next count
  cnt_t rise_q; // Inhibit rise pulse counter
  cnt_t rise_d; // Next rise count
  addr_t addr_q; // Address latched for this cycle
  addr_t addr_d; // Next latched address
  logic clear_wr_q; // Cycle is a clear write
  logic clear_wr_d; // Next clear write flag
  logic split_q; // Cycle is read-modify-write
  logic split_d; // Next split flag

  // Data register, high bit means a stored zero
  word_t data_reg_n_q; // Register output level
  word_t data_reg_n_d; // Next register output

  // Registered outputs
  word_t data_out_q; // Data out buffer
  word_t data_out_d; // Next data out
  logic strobe_q; // Data out strobe
  logic strobe_d; // Next strobe
  logic [`LINE_COUNT-1:0] x_drive_q; // X switches
  logic [`LINE_COUNT-1:0] y_drive_q; // Y switches
  logic drive_wr_q; // Drive polarity, high for write
  logic drive_wr_d; // Next polarity
  word_t inh_lower_q; // Lower half inhibit drivers
  word_t inh_lower_d; // Next lower inhibit
  word_t inh_upper_q; // Upper half inhibit drivers
  word_t inh_upper_d; // Next upper inhibit
  logic rise_out_q; // Inhibit rise pulse
  logic rise_out_d; // Next rise pulse
  logic sink_q; // Sink discharge
  logic sink_d; // Next sink discharge
  logic busy_q; // Cycle in progress
  logic busy_d; // Next busy

  // Decoder and memory hookup
  logic drive_on; // Any drive line may be on
  logic [`LINE_COUNT-1:0] x_lines; // Decoded X line
  logic [`LINE_COUNT-1:0] y_lines; // Decoded Y line
  logic mem_rd; // Read the addressed word
  logic mem_wr; // Write the addressed word
  word_t mem_wdata; // Word written to the cores
  word_t sensed; // Sense pulse per bit
  word_t mem_rd_data_w; // Read data from the planes
  logic inh_half_a; // Inhibit timing, lower half
  logic inh_half_b; // Inhibit timing, upper half
  logic start_fall; // Cycle start went low

  // Two-flop synchronisers for every pin
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_meta_q <= 1'h1;
      start_sync_q <= 1'h1;
      start_last_q <= 1'h1;
      wrs_meta_q <= 1'h1;
      wrs_sync_q <= 1'h1;
      ww_meta_q <= 1'h1;
      ww_sync_q <= 1'h1;
      sc_meta_q <= 1'h1;
      sc_sync_q <= 1'h1;
      addr_meta_q <= '0;
      addr_sync_q <= '0;
      din_meta_q <= '0;
      din_sync_q <= '0;
    end else begin
      start_meta_q <= cycle_start_n;
      start_sync_q <= start_meta_q;
      start_last_q <= start_sync_q;
      wrs_meta_q <= write_start_n;
      wrs_sync_q <= wrs_meta_q;
      ww_meta_q <= word_write_n;
      ww_sync_q <= ww_meta_q;
      sc_meta_q <= split_cycle_n;
      sc_sync_q <= sc_meta_q;
      addr_meta_q <= address;
      addr_sync_q <= addr_meta_q;
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  assign start_fall = start_last_q && !start_sync_q;

  // Sense pulses come from switching cores in the addressed half
  assign sensed = mem_rd_data_w;

  // Memory planes
  core_plane_mem u_mem (
    .sys_clk(sys_clk),
    .reset(reset),
    .rd_en(mem_rd),
    .wr_en(mem_wr),
    .addr(addr_q),
    .wr_data(mem_wdata),
    .rd_data(mem_rd_data_w)
  );

  // X and Y line decoders share the latched address
  drive_decode u_xdec (
    .en(drive_on),
    .sel(addr_q[`X_SEL_LSB +: `LINE_SEL_BITS]),
    .lines(x_lines)
  );
  drive_decode u_ydec (
    .en(drive_on),
    .sel(addr_q[`Y_SEL_LSB +: `LINE_SEL_BITS]),
    .lines(y_lines)
  );

  // Inhibit timing, split by half-plane select
  assign inh_half_a = (state_q == ST_INHIBIT) && !addr_q[`HALF_SEL_BIT];
  assign inh_half_b = (state_q == ST_INHIBIT) && addr_q[`HALF_SEL_BIT];

  // Per-bit inhibit gates
  genvar gb;
  generate
    for (gb = 0; gb < `CORE_BITS; gb = gb + 1) begin : g_inh
      assign inh_lower_d[gb] = data_reg_n_q[gb] && inh_half_a;
      assign inh_upper_d[gb] = data_reg_n_q[gb] && inh_half_b;
    end
  endgenerate

  // Sequencer and datapath next values
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rise_d = rise_q;
    addr_d = addr_q;
    clear_wr_d = clear_wr_q;
    split_d = split_q;
    data_reg_n_d = data_reg_n_q;
    data_out_d = data_out_q;
    strobe_d = 1'h0;
    drive_wr_d = drive_wr_q;
    rise_out_d = 1'h0;
    sink_d = sink_q;
    busy_d = busy_q;
    mem_rd = 1'h0;
    mem_wr = 1'h0;
    mem_wdata = '0;
    drive_on = 1'h0;
    case (state_q)
      // Wait for cycle start; stack held at ground meanwhile
      ST_IDLE: begin
        if (start_fall) begin
          addr_d = addr_sync_q;
          clear_wr_d = !ww_sync_q;
          split_d = !sc_sync_q;
          sink_d = 1'h0;
          busy_d = 1'h1;
          state_d = ST_CLEAR;
        end
      end
      // Data register to the zero state, then start the read
      ST_CLEAR: begin
        data_reg_n_d = '1;
        mem_rd = 1'h1;
        drive_wr_d = 1'h0;
        cnt_d = cnt_t'(`READ_CYC - 1);
        state_d = ST_READ;
      end
      // Read currents on the selected X and Y lines
      ST_READ: begin
        drive_on = 1'h1;
        if (cnt_q == '0) begin
          state_d = ST_SENSE;
        end else begin
          cnt_d = cnt_q - cnt_t'(1);
        end
      end
      // Strobe sense amps; the read left all cores at zero
      ST_SENSE: begin
        mem_wr = 1'h1;
        mem_wdata = '0;
        if (clear_wr_q) begin
          state_d = ST_LOAD;
        end else begin
          data_reg_n_d = data_reg_n_q & ~sensed;
          state_d = ST_OUTPUT;
        end
      end
      // Data out strobe; unsensed bits read as zero
      ST_OUTPUT: begin
        data_out_d = ~data_reg_n_q;
        strobe_d = 1'h1;
        if (split_q) begin
          state_d = ST_WAIT_WR;
        end else begin
          state_d = ST_INHIBIT;
          cnt_d = cnt_t'(`WRITE_CYC - 1);
          rise_d = cnt_t'(`RISE_CYC);
        end
      end
      // Split cycle: hold until write start goes low
      ST_WAIT_WR: begin
        if (!wrs_sync_q) begin
          state_d = ST_LOAD;
        end
      end
      // Write enable samples the input word
      ST_LOAD: begin
        data_reg_n_d = ~din_sync_q;
        cnt_d = cnt_t'(`WRITE_CYC - 1);
        rise_d = cnt_t'(`RISE_CYC);
        state_d = ST_INHIBIT;
      end
      // Write currents; inhibit on bits meant to stay zero
      ST_INHIBIT: begin
        drive_on = 1'h1;
        drive_wr_d = 1'h1;
        if (rise_q != '0) begin
          rise_out_d = 1'h1;
          rise_d = rise_q - cnt_t'(1);
        end
        if (cnt_q == '0) begin
          mem_wr = 1'h1;
          mem_wdata = ~data_reg_n_q;
          state_d = ST_END;
        end else begin
          cnt_d = cnt_q - cnt_t'(1);
        end
      end
      // End of cycle tap: discharge, accept next start
      ST_END: begin
        sink_d = 1'h1;
        busy_d = 1'h0;
        drive_wr_d = 1'h0;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer and datapath registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      rise_q <= '0;
      addr_q <= '0;
      clear_wr_q <= 1'h0;
      split_q <= 1'h0;
      data_reg_n_q <= '1;
      data_out_q <= '0;
      strobe_q <= 1'h0;
      x_drive_q <= '0;
      y_drive_q <= '0;
      drive_wr_q <= 1'h0;
      inh_lower_q <= '0;
      inh_upper_q <= '0;
      rise_out_q <= 1'h0;
      sink_q <= 1'h1;
      busy_q <= 1'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rise_q <= rise_d;
      addr_q <= addr_d;
      clear_wr_q <= clear_wr_d;
      split_q <= split_d;
      data_reg_n_q <= data_reg_n_d;
      data_out_q <= data_out_d;
      strobe_q <= strobe_d;
      x_drive_q <= x_lines;
      y_drive_q <= y_lines;
      drive_wr_q <= drive_wr_d;
      inh_lower_q <= inh_lower_d;
      inh_upper_q <= inh_upper_d;
      rise_out_q <= rise_out_d;
      sink_q <= sink_d;
      busy_q <= busy_d;
    end
  end

  // Ports straight from flops
  assign data_out = data_out_q;
  assign data_out_strobe = strobe_q;
  assign x_drive = x_drive_q;
  assign y_drive = y_drive_q;
  assign drive_write = drive_wr_q;
  assign inhibit_lower = inh_lower_q;
  assign inhibit_upper = inh_upper_q;
  assign inhibit_rise = rise_out_q;
  assign sink_discharge = sink_q;
  assign cycle_busy = busy_q;

endmodule : core_memory_bit_datapath

// [test/core_memory_bit_datapath_props.sv]
// Purpose: Port checker for the core memory datapath.
// Assumes: One clock, synchronous active high reset.
// Notes: Bound to the top module at the foot of this file.
`timescale 1ns/1ns
`include "core_cfg.svh"

module core_memory_bit_datapath_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cycle_busy,
  input wire logic [`LINE_COUNT-1:0] x_drive,
  input wire logic [`LINE_COUNT-1:0] y_drive,
  input wire logic drive_write,
  input wire logic [`CORE_BITS-1:0] inhibit_lower,
  input wire logic [`CORE_BITS-1:0] inhibit_upper,
  input wire logic inhibit_rise,
  input wire logic sink_discharge,
  input wire logic [`CORE_BITS-1:0] data_out,
  input wire logic data_out_strobe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // At most one line on each axis
  property p_one_line; $onehot0(x_drive) && $onehot0(y_drive); endproperty
  a_one_line: assert property (p_one_line)
    else $error("drive lines not one-hot");
  // X and Y lines come on together
  property p_xy_pair; (|x_drive) == (|y_drive); endproperty
  a_xy_pair: assert property (p_xy_pair)
    else $error("x and y drive not paired");
  // Never both halves inhibited
  property p_one_half; !((|inhibit_lower) && (|inhibit_upper)); endproperty
  a_one_half: assert property (p_one_half)
    else $error("both halves inhibited");
  // Inhibit only in the write phase
  property p_inh_phase;
    (|inhibit_lower || |inhibit_upper) |-> drive_write && |x_drive;
  endproperty
  a_inh_phase: assert property (p_inh_phase)
    else $error("inhibit outside write phase");
  // Rise pulse is four cycles wide, within write
  property p_rise_width;
    $rose(inhibit_rise) |-> (drive_write && inhibit_rise)[*4] ##1 !inhibit_rise;
  endproperty
  a_rise_width: assert property (p_rise_width)
    else $error("inhibit rise pulse width wrong");
  // Discharge keeps X lines and lower inhibit quiet
  property p_sink_idle;
    sink_discharge |-> !cycle_busy && !(|x_drive) && !(|inhibit_lower);
  endproperty
  a_sink_idle: assert property (p_sink_idle)
    else $error("lines active during discharge");
  // Cycle end raises discharge
  property p_sink_end; $fell(cycle_busy) |-> sink_discharge; endproperty
  a_sink_end: assert property (p_sink_end)
    else $error("no discharge at cycle end");
  // Discharge only drops as a cycle starts
  property p_sink_hold; $fell(sink_discharge) |-> $rose(cycle_busy); endproperty
  a_sink_hold: assert property (p_sink_hold)
    else $error("discharge dropped without a cycle");
  // Drive lines come on soon after start
  property p_drive_soon; $rose(cycle_busy) |-> ##[1:5] (|x_drive); endproperty
  a_drive_soon: assert property (p_drive_soon)
    else $error("no drive after cycle start");
  // Output word changes only with its strobe
  property p_out_hold; $changed(data_out) |-> data_out_strobe; endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("data out changed without strobe");
endmodule : core_memory_bit_datapath_props

bind core_memory_bit_datapath core_memory_bit_datapath_props props_inst (
  .sys_clk(sys_clk), .reset(reset), .cycle_busy(cycle_busy),
  .x_drive(x_drive), .y_drive(y_drive), .drive_write(drive_write),
  .inhibit_lower(inhibit_lower), .inhibit_upper(inhibit_upper),
  .inhibit_rise(inhibit_rise), .sink_discharge(sink_discharge),
  .data_out(data_out), .data_out_strobe(data_out_strobe));

// [test/mem_host.sv]
// Purpose: External system that runs memory cycles.
// Assumes: Pins change at the falling clock edge.
// Notes: Mode 0 read restore, 1 clear write, 2 split cycle.
`timescale 1ns/1ns

module mem_host import core_pkg::*; (
  input wire logic sys_clk,
  input wire logic cycle_busy,
  input wire logic data_out_strobe,
  output logic cycle_start_n,
  output addr_t address,
  output word_t data_in,
  output logic word_write_n,
  output logic split_cycle_n,
  output logic write_start_n
);
  // Idle pin levels from time zero
  initial begin
    cycle_start_n = 1'b1;
    address = '0;
    data_in = '0;
    word_write_n = 1'b1;
    split_cycle_n = 1'b1;
    write_start_n = 1'b1;
  end

  // One whole memory cycle; ok is low on a hang
  task automatic run(input int mode, input addr_t a, input word_t d,
                     output logic ok);
    int n;
    repeat (4) @(negedge sys_clk);
    address = a;
    data_in = d;
    word_write_n = (mode != 1);
    split_cycle_n = (mode != 2);
    cycle_start_n = 1'b0;
    n = 0;
    while (!cycle_busy && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    ok = cycle_busy;
    // Split cycle: start the write once the read word is out
    if (mode == 2) begin
      n = 0;
      while (!data_out_strobe && n < 100) begin
        @(negedge sys_clk);
        n++;
      end
      @(negedge sys_clk);
      write_start_n = 1'b0;
    end
    n = 0;
    while (cycle_busy && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    ok = ok && !cycle_busy;
    cycle_start_n = 1'b1;
    write_start_n = 1'b1;
    // Stale data turned over so nothing reuses it
    data_in = ~data_in;
  endtask : run
endmodule : mem_host

// [test/core_memory_bit_datapath_test.sv]
// Purpose: Self-checking bench for the core memory datapath.
// Assumes: mem_host drives every pin at the falling edge.
// Notes: About 1700 clocks; watchdog at 100 us.
`timescale 1ns/1ns

module core_memory_bit_datapath_test;
  import core_pkg::*;
  logic sys_clk = 1'b0; // Bench clock
  logic reset = 1'b1; // Held for ten cycles
  logic cycle_start_n, word_write_n, split_cycle_n, write_start_n;
  addr_t address;
  word_t data_in, data_out, inhibit_lower, inhibit_upper, inh_lo, inh_hi;
  logic [127:0] x_drive, y_drive, x_seen, y_seen;
  logic data_out_strobe, drive_write, inhibit_rise, sink_discharge;
  logic cycle_busy, ok;
  logic busy_last = 1'b0; // Busy one edge ago, marks a new cycle
  int err_count = 0;
  int comparisons = 0;
  int strobes = 0;

  always #5 sys_clk = ~sys_clk;

  core_memory_bit_datapath core_memory_bit_datapath_inst (
    .sys_clk(sys_clk), .reset(reset), .cycle_start_n(cycle_start_n),
    .address(address), .data_in(data_in), .word_write_n(word_write_n),
    .split_cycle_n(split_cycle_n), .write_start_n(write_start_n),
    .data_out(data_out), .data_out_strobe(data_out_strobe),
    .x_drive(x_drive), .y_drive(y_drive), .drive_write(drive_write),
    .inhibit_lower(inhibit_lower), .inhibit_upper(inhibit_upper),
    .inhibit_rise(inhibit_rise), .sink_discharge(sink_discharge),
    .cycle_busy(cycle_busy));

  mem_host mem_host_inst (
    .sys_clk(sys_clk), .cycle_busy(cycle_busy),
    .data_out_strobe(data_out_strobe), .cycle_start_n(cycle_start_n),
    .address(address), .data_in(data_in), .word_write_n(word_write_n),
    .split_cycle_n(split_cycle_n), .write_start_n(write_start_n));

  // Gather lines seen during each cycle, restarting on a new one; count every strobe
  always @(posedge sys_clk) begin
    busy_last <= cycle_busy;
    if (cycle_busy) begin
      inh_lo <= (busy_last ? inh_lo : '0) | inhibit_lower;
      inh_hi <= (busy_last ? inh_hi : '0) | inhibit_upper;
      x_seen <= (busy_last ? x_seen : '0) | x_drive;
      y_seen <= (busy_last ? y_seen : '0) | y_drive;
    end
    if (data_out_strobe) strobes <= strobes + 1;
  end

  task automatic check(input string what, input logic [127:0] exp,
                       input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int mode, input addr_t a, input word_t d);
    mem_host_inst.run(mode, a, d, ok);
    check("cycle end", 1, ok);
  endtask : cyc

  // Lines and inhibit of the last cycle for word d at a
  task automatic inhibits(input addr_t a, input word_t d);
    word_t z;
    z = ~d;
    check("lower inhibit", a[13] ? '0 : z, inh_lo);
    check("upper inhibit", a[13] ? z : '0, inh_hi);
    check("x line", 128'h1 << a[6:0], x_seen);
    check("y line", 128'h1 << a[13:7], y_seen);
  endtask : inhibits

  // Clear write, then two reads that must restore the word
  task automatic wr_rd(input addr_t a, input word_t d);
    int s;
    s = strobes;
    cyc(1, a, d);
    inhibits(a, d);
    check("strobes in write", s, strobes);
    cyc(0, a, '0);
    check("read word", d, data_out);
    inhibits(a, d);
    cyc(0, a, '0);
    check("restored word", d, data_out);
    check("read strobes", s + 2, strobes);
  endtask : wr_rd

  task automatic t_reset;
    check("sink after reset", 1, sink_discharge);
    check("busy after reset", 0, cycle_busy);
    $display("test reset done");
  endtask : t_reset

  task automatic t_lower;
    wr_rd(14'h0123, 36'h9_A5C3_0F18);
    $display("test lower half done");
  endtask : t_lower

  task automatic t_upper;
    wr_rd(14'h2ABC, 36'h6_5A3C_F0E7);
    $display("test upper half done");
  endtask : t_upper

  task automatic t_split;
    cyc(1, 14'h1F80, 36'hF_0000_FFFF);
    cyc(2, 14'h1F80, 36'h0_FFFF_0001);
    check("split old word", 36'hF_0000_FFFF, data_out);
    inhibits(14'h1F80, 36'h0_FFFF_0001);
    cyc(0, 14'h1F80, '0);
    check("split new word", 36'h0_FFFF_0001, data_out);
    $display("test split cycle done");
  endtask : t_split

  // Ones, zeros, worst pattern and its complement
  function automatic word_t pat(input int p, input addr_t a);
    if (p < 2) return (p == 0) ? '1 : '0;
    return ((a[6] == a[7]) ^ (p == 3)) ? '1 : '0;
  endfunction : pat

  task automatic t_patterns;
    addr_t al[4] = '{14'h0000, 14'h0040, 14'h20C0, 14'h3FFF};
    for (int p = 0; p < 4; p++) begin
      foreach (al[i]) cyc(1, al[i], pat(p, al[i]));
      foreach (al[i]) begin
        cyc(0, al[i], '0);
        check("pattern word", pat(p, al[i]), data_out);
      end
    end
    $display("test patterns done");
  endtask : t_patterns

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    repeat (3) @(negedge sys_clk);
    t_reset;
    t_lower;
    t_upper;
    t_split;
    t_patterns;
    print_verdict;
  end

  // Watchdog: the tests need about 17 us
  initial begin
    #100000;
    err_count++;
    print_verdict;
  end
endmodule : core_memory_bit_datapath_test
